// *** hw/sit_pkg.sv ***
package sit_pkg;
    // data widths
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int FIFO_W = BYTE_W + 1;
    localparam int FIFO_DEPTH_DEF = 8;
    // spike suppression and link sampling clock
    localparam int SPIKE_NS = 50;
    localparam int PS_PER_NS = 1000;
    localparam int LINK_PERIOD_PS_DEF = 12000;
    // target address, value arbitrary
    localparam logic [ADDR_W-1:0] DEV_ADDR_DEF = 7'h2A;
    // bit counting
    localparam logic [3:0] BIT_NONE = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'h8;
    // byte returned when nothing is staged
    localparam logic [BYTE_W-1:0] NO_DATA = 8'hFF;
    // idle level of both bus lines
    localparam logic [1:0] LINES_HIGH = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_RD = 3'b101,
        ST_RD_ACK = 3'b110
    } sit_state_e;
endpackage

// *** hw/sit_fifo.sv ***
`timescale 1ns/1ps
module sit_fifo #(
    parameter int WIDTH = sit_pkg::FIFO_W,
    parameter int DEPTH = sit_pkg::FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import sit_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
    logic push;
    logic load;

    assign in_ready = (cnt != FULL_CNT);
    assign push = in_valid && in_ready;
    assign load = (cnt != '0) && (!out_valid || out_ready);

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    // storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (load) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(load);
        end
    end

    // registered output stage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (load) begin
                out_data <= mem[rd_ptr];
            end
            out_valid <= load || (out_valid && !out_ready);
        end
    end
endmodule // sit_fifo

// *** hw/sit_target.sv ***
`timescale 1ns/1ps
module sit_target #(
    parameter logic [sit_pkg::ADDR_W-1:0] DEV_ADDR = sit_pkg::DEV_ADDR_DEF,
    parameter int LINK_PERIOD_PS = sit_pkg::LINK_PERIOD_PS_DEF,
    parameter int FIFO_DEPTH = sit_pkg::FIFO_DEPTH_DEF
) (
    // system clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus pins, link sampling clock
    input wire logic link_clk,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // bytes written by the host
    output logic [sit_pkg::BYTE_W-1:0] rx_data,
    output logic rx_first,
    output logic rx_valid,
    input wire logic rx_ready,
    // bytes returned on reads
    input wire logic [sit_pkg::BYTE_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    import sit_pkg::*;
    localparam int SPIKE_CYC = SPIKE_NS * PS_PER_NS / LINK_PERIOD_PS + 1;
    localparam int FLT_W = $clog2(SPIKE_CYC + 1);
    localparam logic [FLT_W-1:0] FLT_LAST = FLT_W'(SPIKE_CYC - 1);

    logic lrst_meta;
    logic lrst_n;
    logic [1:0] pin_meta;
    logic [1:0] pin_s;
    logic [1:0] pin_f;
    logic [FLT_W-1:0] flt_cnt [2];
    logic scl_s, sda_s, scl_f, sda_f, scl_q, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    sit_state_e state;
    logic [BYTE_W-1:0] shift;
    logic [3:0] bit_cnt;
    logic drive, rd_dir, first_pend, host_ack;
    logic rx_tgl, rx_first_hold, rx_ack_meta, rx_ack_s, rx_busy, rx_put;
    logic [BYTE_W-1:0] rx_hold;
    logic rx_req_meta, rx_req_s, rx_done, rx_pend, fifo_in_ready;
    logic tx_tgl, tx_seen_meta, tx_seen_s;
    logic [BYTE_W-1:0] tx_word;
    logic tx_req_meta, tx_req_s, tx_seen, tx_full, tx_take;
    logic [BYTE_W-1:0] tx_next;
    logic [FIFO_W-1:0] fifo_out;

    // link reset, released on link_clk
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_meta <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_meta <= 1'b1;
            lrst_n <= lrst_meta;
        end
    end

    // pin synchronisers
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            pin_meta <= LINES_HIGH;
            pin_s <= LINES_HIGH;
        end else begin
            pin_meta <= {sda_i, scl_i};
            pin_s <= pin_meta;
        end
    end

    // spike filters, level taken only after SPIKE_CYC steady samples
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            flt_cnt <= '{default: '0};
            pin_f <= LINES_HIGH;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pin_s[i] == pin_f[i]) begin
                    flt_cnt[i] <= '0;
                end else if (flt_cnt[i] == FLT_LAST) begin
                    flt_cnt[i] <= '0;
                    pin_f[i] <= pin_s[i];
                end else begin
                    flt_cnt[i] <= flt_cnt[i] + 1'b1;
                end
            end
        end
    end

    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];
    assign scl_f = pin_f[0];
    assign sda_f = pin_f[1];

    // edge history
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    assign start_det = scl_f && scl_q && sda_q && !sda_f;
    assign stop_det = scl_f && scl_q && !sda_q && sda_f;
    assign tx_next = tx_full ? tx_word : NO_DATA;
    assign rx_busy = (rx_tgl != rx_ack_s);
    assign rx_put = (state == ST_WR) && scl_fall && (bit_cnt == BIT_LAST) && !rx_busy;
    assign tx_take = scl_fall && (((state == ST_ADDR_ACK) && drive && rd_dir) || ((state == ST_RD_ACK) && host_ack));

    // byte framing
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state <= ST_IDLE;
            shift <= '0;
            bit_cnt <= BIT_NONE;
            drive <= 1'b0;
            rd_dir <= 1'b0;
            first_pend <= 1'b0;
            host_ack <= 1'b0;
        end else if (start_det) begin
            state <= ST_ADDR;
            bit_cnt <= BIT_NONE;
            drive <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            bit_cnt <= BIT_NONE;
            drive <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    drive <= 1'b0;
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        shift <= {shift[BYTE_W-2:0], sda_f};
                        bit_cnt <= bit_cnt + 1'b1;
                    end else if (scl_fall && bit_cnt == BIT_LAST) begin
                        if (state == ST_WR) begin
                            state <= ST_WR_ACK;
                            drive <= !rx_busy;
                            first_pend <= first_pend && rx_busy;
                        end else if (shift[BYTE_W-1:1] == DEV_ADDR) begin
                            state <= ST_ADDR_ACK;
                            drive <= 1'b1;
                            rd_dir <= shift[0];
                            first_pend <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        if (drive && rd_dir && state == ST_ADDR_ACK) begin
                            state <= ST_RD;
                            shift <= tx_next;
                            drive <= !tx_next[BYTE_W-1];
                            bit_cnt <= BIT_ONE;
                        end else begin
                            state <= drive ? ST_WR : ST_IDLE;
                            drive <= 1'b0;
                            bit_cnt <= BIT_NONE;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt == BIT_LAST) begin
                            state <= ST_RD_ACK;
                            drive <= 1'b0;
                        end else begin
                            shift <= {shift[BYTE_W-2:0], 1'b0};
                            drive <= !shift[BYTE_W-2];
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        host_ack <= !sda_f;
                    end else if (scl_fall) begin
                        if (host_ack) begin
                            state <= ST_RD;
                            shift <= tx_next;
                            drive <= !tx_next[BYTE_W-1];
                            bit_cnt <= BIT_ONE;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    drive <= 1'b0;
                end
            endcase
        end
    end

    // open-drain pins: pull low or release only
    assign sda_o = 1'b0;
    assign sda_oe_n = !drive;
    assign scl_o = 1'b0;
    assign scl_oe_n = 1'b1;

    // received byte handed toward the system side
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_tgl <= 1'b0;
            rx_hold <= '0;
            rx_first_hold <= 1'b0;
            rx_ack_meta <= 1'b0;
            rx_ack_s <= 1'b0;
        end else begin
            rx_ack_meta <= rx_done;
            rx_ack_s <= rx_ack_meta;
            if (rx_put) begin
                rx_tgl <= !rx_tgl;
                rx_hold <= shift;
                rx_first_hold <= first_pend;
            end
        end
    end

    // staged read byte taken from the system side
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            tx_req_meta <= 1'b0;
            tx_req_s <= 1'b0;
            tx_seen <= 1'b0;
        end else begin
            tx_req_meta <= tx_tgl;
            tx_req_s <= tx_req_meta;
            if (tx_take && tx_full) begin
                tx_seen <= tx_req_s;
            end
        end
    end

    assign tx_full = (tx_req_s != tx_seen);

    // system side of both handshakes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_req_meta <= 1'b0;
            rx_req_s <= 1'b0;
            rx_done <= 1'b0;
            tx_seen_meta <= 1'b0;
            tx_seen_s <= 1'b0;
            tx_tgl <= 1'b0;
            tx_word <= '0;
        end else begin
            rx_req_meta <= rx_tgl;
            rx_req_s <= rx_req_meta;
            tx_seen_meta <= tx_seen;
            tx_seen_s <= tx_seen_meta;
            if (rx_pend && fifo_in_ready) begin
                rx_done <= !rx_done;
            end
            if (tx_valid && tx_ready) begin
                tx_word <= tx_data;
                tx_tgl <= !tx_tgl;
            end
        end
    end

    assign rx_pend = (rx_req_s != rx_done);
    assign tx_ready = (tx_tgl == tx_seen_s);

    sit_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(rx_pend),
        .in_ready(fifo_in_ready),
        .in_data({rx_first_hold, rx_hold}),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(fifo_out)
    );

    assign rx_first = fifo_out[FIFO_W-1];
    assign rx_data = fifo_out[BYTE_W-1:0];

    // checks
    sequence s_scl_short_high;
        !scl_f && !scl_s ##1 scl_s [*4] ##1 !scl_s;
    endsequence
    sequence s_sda_short_low;
        sda_f && sda_s ##1 !sda_s [*4] ##1 sda_s;
    endsequence
    sequence s_addr_done;
        state == ST_ADDR && scl_fall && bit_cnt == BIT_LAST;
    endsequence

    property p_scl_spike;
        @(posedge link_clk) disable iff (!lrst_n) s_scl_short_high |-> !scl_f;
    endproperty
    a_scl_spike: assert property (p_scl_spike) else $error("short clock pulse passed filter");

    property p_sda_spike;
        @(posedge link_clk) disable iff (!lrst_n) s_sda_short_low |-> sda_f;
    endproperty
    a_sda_spike: assert property (p_sda_spike) else $error("short data pulse passed filter");

    property p_scl_follow;
        @(posedge link_clk) disable iff (!lrst_n) (scl_s && !scl_f) [*5] |=> scl_f;
    endproperty
    a_scl_follow: assert property (p_scl_follow) else $error("clock level taken too late");

    property p_addr_match;
        @(posedge link_clk) disable iff (!lrst_n)
            s_addr_done and (shift[BYTE_W-1:1] == DEV_ADDR) |=> state == ST_ADDR_ACK && !sda_oe_n;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("own address not acknowledged");

    property p_addr_other;
        @(posedge link_clk) disable iff (!lrst_n)
            s_addr_done and (shift[BYTE_W-1:1] != DEV_ADDR) |=> state == ST_IDLE && sda_oe_n;
    endproperty
    a_addr_other: assert property (p_addr_other) else $error("foreign address answered");

    property p_read_bits;
        @(posedge link_clk) disable iff (!lrst_n) state == ST_RD |-> sda_oe_n == shift[BYTE_W-1];
    endproperty
    a_read_bits: assert property (p_read_bits) else $error("read bit not on data line");

    property p_quiet_line;
        @(posedge link_clk) disable iff (!lrst_n)
            state inside {ST_IDLE, ST_ADDR, ST_WR, ST_RD_ACK} |-> sda_oe_n && scl_oe_n && !sda_o;
    endproperty
    a_quiet_line: assert property (p_quiet_line) else $error("line driven out of turn");

    property p_frame_reset;
        @(posedge link_clk) disable iff (!lrst_n)
            (start_det || stop_det) |=> sda_oe_n && bit_cnt == BIT_NONE ##0 state inside {ST_IDLE, ST_ADDR} [*2];
    endproperty
    a_frame_reset: assert property (p_frame_reset) else $error("start or stop did not restart");

    property p_wr_busy_nack;
        @(posedge link_clk) disable iff (!lrst_n)
            state == ST_WR && scl_fall && bit_cnt == BIT_LAST && rx_busy |=> state == ST_WR_ACK && sda_oe_n;
    endproperty
    a_wr_busy_nack: assert property (p_wr_busy_nack) else $error("byte acknowledged while full");

    property p_rx_push;
        @(posedge clock) disable iff (!rst_n) rx_pend && fifo_in_ready |=> !rx_pend [*2];
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("received byte pushed twice");
endmodule // sit_target

// *** bench/sit_host.sv ***
`timescale 1ns/1ps
module sit_host (
    // system clock
    input wire logic clock,
    // bus line levels
    input wire logic scl,
    input wire logic sda,
    // pull-down requests
    output logic scl_low,
    output logic sda_low
);
    int lo = 12;
    int hi = 8;
    logic glitch = 1'h0;

    initial begin
        scl_low = 1'h0;
        sda_low = 1'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // start or repeated start
    task automatic start();
        sda_low <= 1'h0;
        tick(2);
        scl_low <= 1'h0;
        tick(hi);
        for (int n = 0; n < 100 && !(scl && sda); n++) tick(1);
        sda_low <= 1'h1;
        tick(hi);
        scl_low <= 1'h1;
    endtask

    // one clock pulse, data changed only while the clock is low except for the glitch spike on a 1 bit
    task automatic bit_x(input logic b, output logic r);
        tick(2);
        sda_low <= !b;
        tick(lo / 2);
        if (glitch) begin
            scl_low <= 1'h0;
            #40 scl_low <= 1'h1;
        end
        tick(lo - 2 - lo / 2);
        scl_low <= 1'h0;
        tick(hi / 2);
        r = sda;
        if (glitch && b) begin
            sda_low <= 1'h1;
            #40 sda_low <= 1'h0;
        end
        tick(hi - hi / 2);
        scl_low <= 1'h1;
    endtask

    // eight data pulses and the acknowledge pulse, msb first
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bit_x(d[i], q[i]);
    endtask

    task automatic stop();
        sda_low <= 1'h0;
        tick(4);
        for (int n = 0; n < 9 && !sda; n++) begin
            scl_low <= 1'h0;
            tick(hi);
            scl_low <= 1'h1;
            tick(lo);
        end
        sda_low <= 1'h1;
        tick(lo - 2);
        scl_low <= 1'h0;
        tick(hi);
        sda_low <= 1'h0;
        tick(lo);
    endtask
endmodule // sit_host

// *** bench/sit_target_test.sv ***
`timescale 1ns/1ps
module sit_target_test;
    import sit_pkg::*;

    `define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin failures++; $display("[FAIL] %0t %s", $time, msg); end end

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic ack_n;
        int per;
        logic glitch;
    } sit_row_s;

    logic clock = 1'h0;
    logic link_clk = 1'h0;
    logic rst_n = 1'h0;
    logic rx_ready = 1'h0;
    logic [BYTE_W-1:0] tx_data = 8'h00;
    logic tx_valid = 1'h0;
    logic scl_low, sda_low, scl_o, scl_oe_n, sda_o, sda_oe_n, rx_first, rx_valid, tx_ready;
    logic [BYTE_W-1:0] rx_data;
    logic [8:0] q;
    logic [7:0] d;
    logic f;
    int acked;
    int failures = 0;
    int checks = 0;
    // pulled up unless someone pulls low
    wire scl = !(scl_low || !scl_oe_n);
    wire sda = !(sda_low || !sda_oe_n);

    // write rows: address byte, data byte, expected ack, clocks per bit, spikes
    sit_row_s rows [4] = '{
        '{{DEV_ADDR_DEF, 1'h0}, 8'h5A, 1'h0, 20, 1'h0},
        '{{DEV_ADDR_DEF, 1'h0}, 8'hA5, 1'h0, 50, 1'h1},
        '{{DEV_ADDR_DEF, 1'h0}, 8'h01, 1'h0, 200, 1'h0},
        '{{DEV_ADDR_DEF + 7'h01, 1'h0}, 8'h33, 1'h1, 20, 1'h0}
    };

    initial forever #25 clock = !clock;
    initial begin
        #7.3;
        forever #6 link_clk = !link_clk;
    end

    sit_host sit_host_inst (.clock(clock), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

    sit_target #(.LINK_PERIOD_PS(12000)) sit_target_inst (
        .clock(clock), .rst_n(rst_n), .link_clk(link_clk),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .rx_data(rx_data), .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
    );

    always @(negedge clock) `CHK(scl_oe_n, 1'h1, "clock line pulled")
    always @(negedge clock) `CHK(sda_o, 1'h0, "data driven high")
    always @(negedge clock) `CHK(scl_o, 1'h0, "clock driven high")

    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic pop(output logic [7:0] pd, output logic pf);
        for (int n = 0; n < 200; n++) begin
            @(negedge clock);
            if (rx_valid === 1'h1) begin
                pd = rx_data;
                pf = rx_first;
                @(posedge clock) rx_ready <= 1'h1;
                @(posedge clock) rx_ready <= 1'h0;
                return;
            end
        end
        failures++;
        final_report();
    endtask

    task automatic stage(input logic [7:0] sd);
        for (int n = 0; n < 20; n++) begin
            @(negedge clock);
            if (tx_ready === 1'h1) begin
                @(posedge clock) begin tx_data <= sd; tx_valid <= 1'h1; end
                @(posedge clock) tx_valid <= 1'h0;
                return;
            end
        end
        failures++;
        final_report();
    endtask

    task automatic read_one(input logic [8:0] hd, input logic [7:0] exp);
        sit_host_inst.xfer(hd, q);
        `CHK(q[8:1], exp, "read byte")
    endtask

    initial begin
        repeat (3) @(posedge clock);
        `CHK(sda_oe_n, 1'h1, "reset data release")
        `CHK({rx_valid, tx_ready}, 2'h1, "reset streams")
        rst_n <= 1'h1;
        repeat (5) @(posedge clock);
        $display("reset test done");
        foreach (rows[i]) begin
            sit_host_inst.lo = rows[i].per * 3 / 5;
            sit_host_inst.hi = rows[i].per - sit_host_inst.lo;
            sit_host_inst.glitch = rows[i].glitch;
            sit_host_inst.start();
            sit_host_inst.xfer({rows[i].addr, 1'h1}, q);
            `CHK(q[0], rows[i].ack_n, "address ack")
            sit_host_inst.xfer({rows[i].data, 1'h1}, q);
            `CHK(q[0], rows[i].ack_n, "data ack")
            sit_host_inst.glitch = 1'h0;
            sit_host_inst.stop();
            if (!rows[i].ack_n) begin
                pop(d, f);
                `CHK({f, d}, {1'h1, rows[i].data}, "received byte")
            end else begin
                repeat (20) @(negedge clock);
                `CHK(rx_valid, 1'h0, "stray byte")
            end
            $display("row %0d done", i);
        end
        // fill with the stream stalled, then drain
        sit_host_inst.start();
        sit_host_inst.xfer({DEV_ADDR_DEF, 1'h0, 1'h1}, q);
        acked = 0;
        for (int i = 0; i < 12; i++) begin
            sit_host_inst.xfer({8'(8'h10 + i), 1'h1}, q);
            if (q[0] === 1'h0) acked++;
        end
        sit_host_inst.stop();
        `CHK(acked >= FIFO_DEPTH_DEF + 1 && acked < 12, 1'h1, "fill refusal")
        for (int i = 0; i < acked; i++) begin
            pop(d, f);
            `CHK({f, d}, {i == 0, 8'(8'h10 + i)}, "drain order")
        end
        repeat (20) @(negedge clock);
        `CHK(rx_valid, 1'h0, "drained")
        $display("fill test done");
        // pointer write, repeated start, two reads
        stage(8'hC3);
        sit_host_inst.start();
        sit_host_inst.xfer({DEV_ADDR_DEF, 1'h0, 1'h1}, q);
        sit_host_inst.xfer({8'h07, 1'h1}, q);
        sit_host_inst.start();
        sit_host_inst.xfer({DEV_ADDR_DEF, 1'h1, 1'h1}, q);
        `CHK(q[0], 1'h0, "read address ack")
        stage(8'h3C);
        read_one(9'h1FE, 8'hC3);
        read_one(9'h1FF, 8'h3C);
        repeat (4) @(negedge clock);
        `CHK(sda_oe_n, 1'h1, "release after nack")
        sit_host_inst.stop();
        pop(d, f);
        `CHK({f, d}, {1'h1, 8'h07}, "pointer byte")
        $display("read test done");
        // reset while the port drives a read bit
        stage(8'h00);
        sit_host_inst.start();
        sit_host_inst.xfer({DEV_ADDR_DEF, 1'h1, 1'h1}, q);
        repeat (4) @(negedge clock);
        `CHK(sda_oe_n, 1'h0, "read bit driven")
        @(posedge clock) rst_n <= 1'h0;
        @(negedge clock);
        `CHK({sda_oe_n, rx_valid, tx_ready}, 3'h5, "mid-run reset")
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        repeat (5) @(posedge clock);
        sit_host_inst.stop();
        sit_host_inst.start();
        sit_host_inst.xfer({DEV_ADDR_DEF, 1'h1, 1'h1}, q);
        read_one(9'h1FF, NO_DATA);
        sit_host_inst.stop();
        $display("second reset test done");
        // host abandons a read while the port holds the data line low
        stage(8'h00);
        sit_host_inst.start();
        sit_host_inst.xfer({DEV_ADDR_DEF, 1'h1, 1'h1}, q);
        sit_host_inst.stop();
        `CHK(sda_oe_n, 1'h1, "stuck data freed")
        $display("stuck line test done");
        final_report();
    end

    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        final_report();
    end
endmodule // sit_target_test
